// ### logic/osr_pkg.sv
package osr_pkg;
  // register offsets
  localparam logic [3:0] OSR_ADDR_CFG = 4'h0;
  localparam logic [3:0] OSR_ADDR_STAT = 4'h4;
  localparam logic [3:0] OSR_ADDR_CNT = 4'h8;
  // config field positions
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_CS_D = 2;
  localparam int CFG_SS_B = 3;
  localparam int CFG_DS_B = 4;
  // status field positions
  localparam int STAT_OP32 = 0;
  localparam int STAT_AD32 = 1;
  localparam int STAT_SP32 = 2;
  localparam int STAT_GATE32 = 3;
  localparam int STAT_CS_D = 4;
  localparam int STAT_MODE_LSB = 8;
  // reset values
  localparam logic RST_FLAG = 1'b0;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  // prefix bytes
  localparam logic [7:0] OSR_PFX_OPSZ = 8'h66;
  localparam logic [7:0] OSR_PFX_ADSZ = 8'h67;
  // limits and stack slot sizes in bytes
  localparam logic [31:0] OSR_LIM16 = 32'h0000ffff;
  localparam logic [31:0] OSR_LIM32 = 32'hffffffff;
  localparam logic [2:0] OSR_SLOT16 = 3'h2;
  localparam logic [2:0] OSR_SLOT32 = 3'h4;

  typedef enum logic [1:0] {
    mode_real,
    mode_prot,
    mode_v86,
    mode_smm
  } osr_mode_e;

  // native 16-bit modes ignore the CS D and SS B size flags
  function automatic logic osr_native16(input osr_mode_e m);
    return (m != mode_prot);
  endfunction
endpackage

// ### logic/osr_size_if.sv
`timescale 1ns/1ps
interface osr_size_if;
  logic ad32;
  logic sp32;
  modport drv (output ad32, output sp32);
  modport sink (input ad32, input sp32);
endinterface

// ### logic/osr_prefix_scan.sv
`timescale 1ns/1ps
module osr_prefix_scan
  import osr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic byte_last,
  output logic [1:0] inv
);
  // bit 0 operand-size prefix seen, bit 1 address-size prefix seen
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_flag
      localparam logic [7:0] CODE = (i == 0) ? OSR_PFX_OPSZ : OSR_PFX_ADSZ;
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          inv[i] <= RST_FLAG;
        end else if (byte_valid && byte_last) begin
          inv[i] <= 1'b0;
        end else if (byte_valid && byte_data == CODE) begin
          inv[i] <= 1'b1;
        end
      end
    end
  endgenerate
endmodule

// ### logic/osr_offset_clip.sv
`timescale 1ns/1ps
module osr_offset_clip
  import osr_pkg::*;
(
  osr_size_if.sink sz,
  input wire logic ea_stack_implicit,
  input wire logic [31:0] ea_raw,
  input wire logic gate_is32,
  input wire logic [31:0] gate_offset,
  output logic [31:0] ea_clip,
  output logic [31:0] gate_clip,
  output logic [2:0] gate_slot
);
  logic wide;
  // implicit stack uses stack width, explicit uses address size
  assign wide = ea_stack_implicit ? sz.sp32 : sz.ad32;
  // 16-bit offsets reach only the first 64 KBytes
  assign ea_clip = wide ? ea_raw : (ea_raw & OSR_LIM16);
  assign gate_clip = gate_is32 ? gate_offset
                               : (gate_offset & OSR_LIM16);
  assign gate_slot = gate_is32 ? OSR_SLOT32 : OSR_SLOT16;
endmodule

// ### logic/osr_resolver.sv
`timescale 1ns/1ps
module osr_resolver
  import osr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ifetch_valid,
  input wire logic [7:0] ifetch_byte,
  input wire logic ifetch_last,
  input wire logic ea_valid,
  input wire logic ea_stack_implicit,
  input wire logic [31:0] ea_raw,
  input wire logic gate_valid,
  input wire logic gate_is32,
  input wire logic [31:0] gate_offset,
  output logic res_valid,
  output logic res_op32,
  output logic res_ad32,
  output logic res_sp32,
  output logic ea_out_valid,
  output logic [31:0] ea_out,
  output logic [31:0] ds_limit,
  output logic xfer_valid,
  output logic xfer_op32,
  output logic xfer_sp32,
  output logic [2:0] xfer_slot,
  output logic [31:0] xfer_offset
);
  osr_mode_e mode_r;
  logic cs_d_r;
  logic ss_b_r;
  logic ds_b_r;
  logic sp32_r;
  logic gate32_r;
  logic [31:0] cnt_r;
  logic [31:0] rdata_r;
  logic res_valid_r;
  logic res_op32_r;
  logic res_ad32_r;
  logic res_sp32_r;
  logic ea_valid_r;
  logic [31:0] ea_r;
  logic [31:0] ds_limit_r;
  logic xfer_valid_r;
  logic xfer_op32_r;
  logic xfer_sp32_r;
  logic [2:0] xfer_slot_r;
  logic [31:0] xfer_off_r;
  logic [1:0] pfx_inv;
  logic def32;
  logic cfg_wr;
  logic insn_end;
  osr_mode_e mode_nxt;
  logic [31:0] ea_clip;
  logic [31:0] gate_clip;
  logic [2:0] gate_slot;

  osr_size_if sz_if ();

  assign cfg_wr = reg_wr && reg_addr == OSR_ADDR_CFG;
  assign insn_end = ifetch_valid && ifetch_last;
  assign mode_nxt = osr_mode_e'(reg_wdata[CFG_MODE_LSB +: 2]);
  // descriptor flag only counts outside native 16-bit modes
  assign def32 = !osr_native16(mode_r) && cs_d_r;

  osr_prefix_scan u_pfx (
    .clk_sys(clk_sys),
    .rst(rst),
    .byte_valid(ifetch_valid),
    .byte_data(ifetch_byte),
    .byte_last(ifetch_last),
    .inv(pfx_inv)
  );

  assign sz_if.ad32 = res_ad32_r;
  assign sz_if.sp32 = sp32_r;

  osr_offset_clip u_clip (
    .sz(sz_if.sink),
    .ea_stack_implicit(ea_stack_implicit),
    .ea_raw(ea_raw),
    .gate_is32(gate_is32),
    .gate_offset(gate_offset),
    .ea_clip(ea_clip),
    .gate_clip(gate_clip),
    .gate_slot(gate_slot)
  );

  // segment and mode state written by software
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_r <= mode_real;
      cs_d_r <= RST_FLAG;
      ss_b_r <= RST_FLAG;
      ds_b_r <= RST_FLAG;
    end else if (cfg_wr) begin
      mode_r <= mode_nxt;
      cs_d_r <= reg_wdata[CFG_CS_D];
      ss_b_r <= reg_wdata[CFG_SS_B];
      ds_b_r <= reg_wdata[CFG_DS_B];
    end
  end

  // active stack width follows segment loads and gate transfers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sp32_r <= RST_FLAG;
    end else if (cfg_wr) begin
      sp32_r <= !osr_native16(mode_nxt) && reg_wdata[CFG_SS_B];
    end else if (gate_valid) begin
      sp32_r <= gate_is32;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gate32_r <= RST_FLAG;
    end else if (gate_valid) begin
      gate32_r <= gate_is32;
    end
  end

  // per-instruction sizes, prefixes inverting the default in any mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      res_valid_r <= RST_FLAG;
      res_op32_r <= RST_FLAG;
      res_ad32_r <= RST_FLAG;
      res_sp32_r <= RST_FLAG;
    end else begin
      res_valid_r <= insn_end;
      if (insn_end) begin
        res_op32_r <= def32 ^ pfx_inv[0];
        res_ad32_r <= def32 ^ pfx_inv[1];
        res_sp32_r <= sp32_r;
      end
    end
  end

  // effective address, width from the current instruction, or from the stack width for implicit stack use
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ea_valid_r <= RST_FLAG;
      ea_r <= RST_WORD;
    end else begin
      ea_valid_r <= ea_valid;
      if (ea_valid) begin
        ea_r <= ea_clip;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ds_limit_r <= OSR_LIM16;
    end else begin
      ds_limit_r <= ds_b_r ? OSR_LIM32 : OSR_LIM16;
    end
  end

  // gate transfer attributes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xfer_valid_r <= RST_FLAG;
      xfer_op32_r <= RST_FLAG;
      xfer_sp32_r <= RST_FLAG;
      xfer_slot_r <= OSR_SLOT16;
      xfer_off_r <= RST_WORD;
    end else begin
      xfer_valid_r <= gate_valid;
      if (gate_valid) begin
        xfer_op32_r <= gate_is32;
        xfer_sp32_r <= gate_is32;
        xfer_slot_r <= gate_slot;
        xfer_off_r <= gate_clip;
      end
    end
  end

  // count of instructions that carried a size prefix
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= RST_WORD;
    end else if (reg_wr && reg_addr == OSR_ADDR_CNT) begin
      cnt_r <= RST_WORD;
    end else if (insn_end && pfx_inv != 2'h0) begin
      cnt_r <= cnt_r + 32'h00000001;
    end
  end

  // read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= RST_WORD;
    end else if (reg_rd) begin
      case (reg_addr)
        OSR_ADDR_CFG: begin
          rdata_r <= RST_WORD;
          rdata_r[CFG_MODE_LSB +: 2] <= mode_r;
          rdata_r[CFG_CS_D] <= cs_d_r;
          rdata_r[CFG_SS_B] <= ss_b_r;
          rdata_r[CFG_DS_B] <= ds_b_r;
        end
        OSR_ADDR_STAT: begin
          rdata_r <= RST_WORD;
          rdata_r[STAT_OP32] <= res_op32_r;
          rdata_r[STAT_AD32] <= res_ad32_r;
          rdata_r[STAT_SP32] <= sp32_r;
          rdata_r[STAT_GATE32] <= gate32_r;
          rdata_r[STAT_CS_D] <= def32;
          rdata_r[STAT_MODE_LSB +: 2] <= mode_r;
        end
        OSR_ADDR_CNT: begin
          rdata_r <= cnt_r;
        end
        default: begin
          rdata_r <= RST_WORD;
        end
      endcase
    end else begin
      rdata_r <= RST_WORD;
    end
  end

  assign reg_rdata = rdata_r;
  assign res_valid = res_valid_r;
  assign res_op32 = res_op32_r;
  assign res_ad32 = res_ad32_r;
  assign res_sp32 = res_sp32_r;
  assign ea_out_valid = ea_valid_r;
  assign ea_out = ea_r;
  assign ds_limit = ds_limit_r;
  assign xfer_valid = xfer_valid_r;
  assign xfer_op32 = xfer_op32_r;
  assign xfer_sp32 = xfer_sp32_r;
  assign xfer_slot = xfer_slot_r;
  assign xfer_offset = xfer_off_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_segment_default: assert property (
    insn_end && mode_r == mode_prot && cs_d_r && pfx_inv == 2'h0
    |=> res_op32 && res_ad32)
    else $error("32-bit segment default not applied");

  a_native_sixteen: assert property (
    insn_end && (mode_r == mode_real || mode_r == mode_v86)
    && pfx_inv == 2'h0 |=> !res_op32 && !res_ad32)
    else $error("native mode default not 16-bit");

  a_smm_sixteen: assert property (
    insn_end && mode_r == mode_smm && pfx_inv == 2'h0
    |=> !res_op32 && !res_ad32)
    else $error("management mode default not 16-bit");

  a_opsize_invert: assert property (
    ifetch_valid && !ifetch_last && ifetch_byte == OSR_PFX_OPSZ
    ##1 insn_end |=> res_op32 != $past(def32))
    else $error("operand prefix did not invert size");

  a_adsize_invert: assert property (
    ifetch_valid && !ifetch_last && ifetch_byte == OSR_PFX_ADSZ && !pfx_inv[0]
    ##1 insn_end |=> res_ad32 != $past(def32) && res_op32 == $past(def32))
    else $error("address prefix wrong or leaked");

  a_override_once: assert property (
    insn_end |=> pfx_inv == 2'h0)
    else $error("override outlived its instruction");

  a_v86_prefix: assert property (
    mode_r == mode_v86 && ifetch_valid && !ifetch_last
    && ifetch_byte == OSR_PFX_OPSZ ##1 insn_end |=> res_op32)
    else $error("prefix ignored in virtual-8086 mode");

  a_implicit_stack: assert property (
    ea_valid && ea_stack_implicit && !sp32_r
    |=> ea_out_valid && ea_out[31:16] == 16'h0000)
    else $error("16-bit stack reference not clipped");

  a_explicit_wide: assert property (
    ea_valid && !ea_stack_implicit && res_ad32_r
    |=> ea_out == $past(ea_raw))
    else $error("explicit 32-bit address altered");

  a_ea_clip: assert property (
    ea_valid && !ea_stack_implicit && !res_ad32_r
    |=> ea_out == {16'h0000, $past(ea_raw[15:0])})
    else $error("16-bit address not limited");

  a_ds_limit: assert property (
    cfg_wr ##1 !cfg_wr |=> ds_limit == ($past(ds_b_r) ? OSR_LIM32 : OSR_LIM16))
    else $error("expand-down limit wrong");

  a_gate_sizes: assert property (
    gate_valid |=> xfer_valid && xfer_op32 == $past(gate_is32)
    && xfer_sp32 == $past(gate_is32) && ($past(cfg_wr) || sp32_r == xfer_sp32))
    else $error("gate type not applied");

  a_gate16_offset: assert property (
    gate_valid && !gate_is32 |=> xfer_offset <= OSR_LIM16
    && xfer_slot == OSR_SLOT16)
    else $error("16-bit gate offset too wide");

  a_sp_switch: assert property (
    cfg_wr |=> sp32_r == $past(mode_nxt == mode_prot && reg_wdata[CFG_SS_B]))
    else $error("stack width did not follow segment");

  c_both_prefixes: cover property (
    ifetch_valid && ifetch_byte == OSR_PFX_OPSZ ##1
    ifetch_valid && ifetch_byte == OSR_PFX_ADSZ ##1 insn_end);
  c_gate32: cover property (gate_valid && gate_is32);
  c_gate16: cover property (gate_valid && !gate_is32);
  c_v86_wide: cover property (mode_r == mode_v86 && res_valid && res_op32);
endmodule

// ### verif/osr_resolver_bench.sv
`timescale 1ns/1ps
module osr_resolver_bench;
  import osr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic ifetch_valid = 1'b0;
  logic [7:0] ifetch_byte = 8'h00;
  logic ifetch_last = 1'b0;
  logic ea_valid = 1'b0;
  logic ea_stack_implicit = 1'b0;
  logic [31:0] ea_raw = 32'h0;
  logic gate_valid = 1'b0;
  logic gate_is32 = 1'b0;
  logic [31:0] gate_offset = 32'h0;
  logic res_valid, res_op32, res_ad32, res_sp32, ea_out_valid;
  logic xfer_valid, xfer_op32, xfer_sp32;
  logic [31:0] ea_out, ds_limit, xfer_offset;
  logic [2:0] xfer_slot;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  integer seed = 32'h81aff174;
  logic [31:0] v;
  logic [1:0] m_mode = 2'h0;
  logic m_cs = 0, m_ss = 0, m_ds = 0, m_sp = 0, m_ad = 0, m_op = 0, m_g32 = 0;
  int m_cnt = 0;

  osr_resolver dut_u (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ifetch_valid(ifetch_valid),
    .ifetch_byte(ifetch_byte), .ifetch_last(ifetch_last),
    .ea_valid(ea_valid), .ea_stack_implicit(ea_stack_implicit),
    .ea_raw(ea_raw), .gate_valid(gate_valid), .gate_is32(gate_is32),
    .gate_offset(gate_offset), .res_valid(res_valid),
    .res_op32(res_op32), .res_ad32(res_ad32), .res_sp32(res_sp32),
    .ea_out_valid(ea_out_valid), .ea_out(ea_out), .ds_limit(ds_limit),
    .xfer_valid(xfer_valid), .xfer_op32(xfer_op32),
    .xfer_sp32(xfer_sp32), .xfer_slot(xfer_slot),
    .xfer_offset(xfer_offset)
  );

  always #2 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one compare per kind of result, all counted in chk
  task automatic chk_res(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask

  task automatic chk_ea(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask

  task automatic chk_xfer(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask

  task test_done;
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      test_done();
    end
  end

  // register bus write, one strobe cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] dat);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // register bus read, data stands one cycle then returns to zero
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk_reg(reg_rdata, exp);
    @(posedge clk_sys);
    #1;
    chk_reg(reg_rdata, 32'h0);
  endtask

  task automatic cfg(input logic [1:0] m, input logic cs, ss, ds);
    m_mode = m;
    m_cs = cs;
    m_ss = ss;
    m_ds = ds;
    m_sp = (m == 2'h1) & ss;
    wr(OSR_ADDR_CFG, {27'h0, ds, ss, cs, m});
  endtask

  // one instruction, prefixes first, op prefix optionally doubled
  task automatic insn(input logic po, pa, dup);
    logic [7:0] q[$];
    logic def;
    q = {};
    if (po) q.push_back(OSR_PFX_OPSZ);
    if (pa) q.push_back(OSR_PFX_ADSZ);
    if (po && dup) q.push_back(OSR_PFX_OPSZ);
    foreach (q[k]) begin
      @(posedge clk_sys);
      ifetch_valid <= 1'b1;
      ifetch_byte <= q[k];
      ifetch_last <= 1'b0;
    end
    @(posedge clk_sys);
    ifetch_valid <= 1'b1;
    ifetch_byte <= 8'($random(seed));
    ifetch_last <= 1'b1;
    @(posedge clk_sys);
    ifetch_valid <= 1'b0;
    ifetch_last <= 1'b0;
    #1;
    def = (m_mode == 2'h1) & m_cs;
    m_op = def ^ po;
    m_ad = def ^ pa;
    if (po | pa) m_cnt++;
    chk_res(res_valid, 32'h1);
    chk_res(res_op32, m_op);
    chk_res(res_ad32, m_ad);
    chk_res(res_sp32, m_sp);
    chk_res(ds_limit, m_ds ? OSR_LIM32 : OSR_LIM16);
  endtask

  task automatic ea(input logic imp);
    logic [31:0] raw;
    logic w;
    raw = $random(seed);
    @(posedge clk_sys);
    ea_valid <= 1'b1;
    ea_stack_implicit <= imp;
    ea_raw <= raw;
    @(posedge clk_sys);
    ea_valid <= 1'b0;
    #1;
    w = imp ? m_sp : m_ad;
    chk_ea(ea_out_valid, 32'h1);
    chk_ea(ea_out, w ? raw : raw & OSR_LIM16);
  endtask

  task automatic gate(input logic g);
    logic [31:0] off;
    off = $random(seed);
    @(posedge clk_sys);
    gate_valid <= 1'b1;
    gate_is32 <= g;
    gate_offset <= off;
    @(posedge clk_sys);
    gate_valid <= 1'b0;
    #1;
    m_sp = g;
    m_g32 = g;
    chk_xfer(xfer_valid, 32'h1);
    chk_xfer({xfer_op32, xfer_sp32}, {2{g}});
    chk_xfer(xfer_slot, g ? OSR_SLOT32 : OSR_SLOT16);
    chk_xfer(xfer_offset, g ? off : off & OSR_LIM16);
  endtask

  task automatic stat;
    rd(OSR_ADDR_STAT, {22'h0, m_mode, 3'h0, (m_mode == 2'h1) & m_cs,
                       m_g32, m_sp, m_ad, m_op});
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk_res(ds_limit, OSR_LIM16);
    chk_xfer(xfer_slot, OSR_SLOT16);
    chk_res({res_valid, res_op32, res_ad32, res_sp32}, 32'h0);
    rd(OSR_ADDR_CFG, 32'h0);
    rd(4'hc, 32'h0);
    for (int i = 0; i < 32; i++) begin
      v = $random(seed);
      cfg(2'(i), v[0], v[1], v[2]);
      for (int p = 3; p >= 0; p--) begin
        insn(p[0], p[1], v[3]);
        ea(1'b0);
      end
      gate(v[4]);
      // the stack access after the gate keeps the gate's stack width
      ea(1'b1);
      stat();
      if (i == 15) begin
        rd(OSR_ADDR_CNT, 32'(m_cnt));
        wr(OSR_ADDR_CNT, 32'($random(seed)));
        m_cnt = 0;
        wr(OSR_ADDR_STAT, 32'($random(seed)));
        stat();
      end
    end
    rd(OSR_ADDR_CNT, 32'(m_cnt));
    test_done();
  end
endmodule
